/* mdp_pkg.sv */
package mdp_pkg;
  // channel count and address space
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned PW_WORDS = 2 * NUM_CH;
  localparam logic [15:0] EN_COIL_BASE = 16'd100;
  localparam logic [15:0] ALM_COIL_BASE = 16'd364;
  localparam logic [15:0] PW_HREG_BASE = 16'd100;
  localparam logic [15:0] PW_RESET = 16'h03e8;
  localparam logic [15:0] PW_OFF = 16'h0000;
  // access kinds on the register port
  localparam logic KIND_COIL = 1'b0;
  localparam logic KIND_HREG = 1'b1;
  // millisecond timebase from a 25 ns clock
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned MS_PERIOD_PS = 1000000000;
  localparam int unsigned MS_CYCLES = MS_PERIOD_PS / CLK_PERIOD_PS;
  // phase of one pulse generator
  typedef enum logic [1:0] {
    MDP_IDLE = 2'b00,
    MDP_HIGH = 2'b01,
    MDP_LOW = 2'b10
  } mdp_phase_t;
endpackage

/* mdp_chan_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mdp_chan_if;
  logic tick;
  logic active;
  logic [15:0] hi_w;
  logic [15:0] lo_w;
  logic out;
  modport gen (input tick, input active, input hi_w, input lo_w, output out);
  modport ctl (output tick, output active, output hi_w, output lo_w, input out);
endinterface
`default_nettype wire

/* mdp_chan_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module mdp_chan_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // channel settings and output
  mdp_chan_if.gen ch
);
  import mdp_pkg::*;

  mdp_phase_t state_ff, nxt_state;
  logic [15:0] ms_cnt_ff, nxt_ms_cnt;
  logic out_ff, nxt_out;

  // phase sequencer: high for hi_w ms, low for lo_w ms, repeat
  always_comb begin
    nxt_state = state_ff;
    nxt_ms_cnt = ms_cnt_ff;
    if (!ch.active) begin
      nxt_state = MDP_IDLE; // see R7
      nxt_ms_cnt = '0;
    end else begin
      case (state_ff)
        MDP_IDLE: begin
          nxt_state = MDP_HIGH; // first period may lose up to 1 ms of phase
          nxt_ms_cnt = '0;
        end
        MDP_HIGH: begin
          if (ch.tick) begin
            nxt_ms_cnt = ms_cnt_ff + 16'd1; // see R4
            if (nxt_ms_cnt >= ch.hi_w) begin
              nxt_state = MDP_LOW; // see R7
              nxt_ms_cnt = '0;
            end
          end
        end
        MDP_LOW: begin
          if (ch.tick) begin
            nxt_ms_cnt = ms_cnt_ff + 16'd1;
            if (nxt_ms_cnt >= ch.lo_w) begin
              nxt_state = MDP_HIGH; // see R7
              nxt_ms_cnt = '0;
            end
          end
        end
        default: begin
          nxt_state = MDP_IDLE;
          nxt_ms_cnt = '0;
        end
      endcase
    end
    nxt_out = ch.active && (nxt_state == MDP_HIGH); // low whenever stopped
  end

  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= MDP_IDLE;
      ms_cnt_ff <= '0;
      out_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ms_cnt_ff <= nxt_ms_cnt;
      out_ff <= nxt_out;
    end
  end

  assign ch.out = out_ff;

  property p_stop_low;
    @(posedge clk) disable iff (!rstn) !ch.active |=> !out_ff;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("output not low after stop"); // see R7

  property p_high_holds;
    @(posedge clk) disable iff (!rstn)
      (state_ff == MDP_HIGH && ch.active && !ch.tick) |=> out_ff;
  endproperty
  a_high_holds: assert property (p_high_holds) else $error("high phase ended early"); // see R7
endmodule
`default_nettype wire

/* mdp_pwm.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - each channel has a PWM enable coil in one contiguous range that starts its pulse output.
// R2 - each channel has an alarm enable coil that starts pulse output once the watchdog expires.
// R3 - each channel holds a high width word then a low width word in consecutive registers.
// R4 - widths count in 1 ms units, with timing good to about 5 ms.
// R5 - the host writes nonzero widths only from 10 to 65535 ms.
// R6 - a zero width stops pulse output on that channel whatever its enable says.
// R7 - an active channel drives high for the high width, low for the low width, and repeats.
module mdp_pwm #(
  parameter int unsigned MS_CYC = mdp_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // modbus coil and holding register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_kind,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_ff,
  output logic reg_ack_ff,
  output logic reg_err_ff,
  // host watchdog expiry, asynchronous level
  input wire logic wdt_expired,
  // digital outputs
  output logic [mdp_pkg::NUM_CH-1:0] do_out
);
  import mdp_pkg::*;

  // true when addr falls in an n-entry window of the given kind
  function automatic logic in_range(input logic kind, input logic [15:0] addr,
                                    input logic want, input logic [15:0] base,
                                    input int unsigned n);
    in_range = (kind == want) && (addr >= base) && (addr < base + 16'(n));
  endfunction

  logic [NUM_CH-1:0] en_ff, nxt_en;
  logic [NUM_CH-1:0] alm_ff, nxt_alm;
  logic [15:0] pw_ff [PW_WORDS];
  logic [15:0] nxt_pw [PW_WORDS];
  logic [15:0] nxt_rdata;
  logic nxt_ack, nxt_err;
  logic [15:0] off_en, off_alm, off_pw;
  logic hit_en, hit_alm, hit_pw;
  logic wdt_s1_ff, wdt_s2_ff;
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick_ff, nxt_tick;
  logic [NUM_CH-1:0] act;

  // address decode shared by reads and writes
  always_comb begin
    hit_en = in_range(reg_kind, reg_addr, KIND_COIL, EN_COIL_BASE, NUM_CH);
    hit_alm = in_range(reg_kind, reg_addr, KIND_COIL, ALM_COIL_BASE, NUM_CH);
    hit_pw = in_range(reg_kind, reg_addr, KIND_HREG, PW_HREG_BASE, PW_WORDS);
    off_en = reg_addr - EN_COIL_BASE;
    off_alm = reg_addr - ALM_COIL_BASE;
    off_pw = reg_addr - PW_HREG_BASE;
  end

  // register file: writes take effect next edge, reads answer next edge
  always_comb begin
    nxt_en = en_ff;
    nxt_alm = alm_ff;
    nxt_pw = pw_ff;
    nxt_rdata = reg_rdata_ff;
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    if (reg_wr) begin
      nxt_ack = 1'b1;
      nxt_err = !(hit_en || hit_alm || hit_pw); // unmapped write is dropped
      if (hit_en) begin
        nxt_en[off_en[2:0]] = reg_wdata[0]; // see R1
      end
      if (hit_alm) begin
        nxt_alm[off_alm[2:0]] = reg_wdata[0]; // see R2
      end
      if (hit_pw) begin
        nxt_pw[off_pw[3:0]] = reg_wdata; // see R3
      end
    end else if (reg_rd) begin
      nxt_ack = 1'b1;
      nxt_err = !(hit_en || hit_alm || hit_pw);
      nxt_rdata = '0; // unmapped reads return zero
      if (hit_en) begin
        nxt_rdata = {15'h0000, en_ff[off_en[2:0]]};
      end
      if (hit_alm) begin
        nxt_rdata = {15'h0000, alm_ff[off_alm[2:0]]};
      end
      if (hit_pw) begin
        nxt_rdata = pw_ff[off_pw[3:0]];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_ff <= '0;
      alm_ff <= '0;
      for (int i = 0; i < PW_WORDS; i++) begin
        pw_ff[i] <= PW_RESET;
      end
      reg_rdata_ff <= '0;
      reg_ack_ff <= 1'b0;
      reg_err_ff <= 1'b0;
    end else begin
      en_ff <= nxt_en;
      alm_ff <= nxt_alm;
      pw_ff <= nxt_pw;
      reg_rdata_ff <= nxt_rdata;
      reg_ack_ff <= nxt_ack;
      reg_err_ff <= nxt_err;
    end
  end

  // every request gets its answer on the very next edge, never later
  property p_ack_next;
    @(posedge clk) disable iff (!rstn) (reg_wr || reg_rd) |=> reg_ack_ff;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered"); // see R3

  // a read outside every window flags an error and hands back zero
  property p_rd_unmapped;
    @(posedge clk) disable iff (!rstn)
      (reg_rd && !reg_wr && !(hit_en || hit_alm || hit_pw))
      |=> (reg_err_ff && reg_rdata_ff == 16'h0000);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused"); // see R3

  // watchdog level comes from another domain, two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdt_s1_ff <= 1'b0;
      wdt_s2_ff <= 1'b0;
    end else begin
      wdt_s1_ff <= wdt_expired;
      wdt_s2_ff <= wdt_s1_ff;
    end
  end

  // millisecond tick; exact 1 ms beats the 5 ms resolution needed
  always_comb begin
    nxt_tick = 1'b0;
    nxt_tick_cnt = tick_cnt_ff + 32'd1;
    if (tick_cnt_ff == 32'(MS_CYC - 1)) begin
      nxt_tick_cnt = '0;
      nxt_tick = 1'b1; // see R4
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
    end
  end

  property p_tick_period;
    @(posedge clk) disable iff (!rstn) tick_ff |-> $past(tick_cnt_ff) == 32'(MS_CYC - 1);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("ms tick off period"); // see R4

  // per-channel activation and generators
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      mdp_chan_if chif ();
      // zero in either width vetoes the channel; host keeps nonzero in 10..65535
      assign act[g] = (en_ff[g] || (alm_ff[g] && wdt_s2_ff)) // see R1 see R2
                      && (pw_ff[2*g] != PW_OFF) && (pw_ff[2*g+1] != PW_OFF); // see R6 see R5
      assign chif.tick = tick_ff;
      assign chif.active = act[g];
      assign chif.hi_w = pw_ff[2*g];
      assign chif.lo_w = pw_ff[2*g+1];
      assign do_out[g] = chif.out;

      mdp_chan_gen u_gen (
        .clk(clk),
        .rstn(rstn),
        .ch(chif.gen)
      );

      property p_zero_off;
        @(posedge clk) disable iff (!rstn)
          (pw_ff[2*g] == PW_OFF || pw_ff[2*g+1] == PW_OFF) |=> !do_out[g];
      endproperty
      a_zero_off: assert property (p_zero_off) else $error("zero width did not stop output"); // see R6

      property p_en_write;
        @(posedge clk) disable iff (!rstn)
          (reg_wr && reg_kind == KIND_COIL && reg_addr == EN_COIL_BASE + 16'(g))
          |=> en_ff[g] == $past(reg_wdata[0]);
      endproperty
      a_en_write: assert property (p_en_write) else $error("enable coil not stored"); // see R1

      property p_alm_write;
        @(posedge clk) disable iff (!rstn)
          (reg_wr && reg_kind == KIND_COIL && reg_addr == ALM_COIL_BASE + 16'(g))
          |=> alm_ff[g] == $past(reg_wdata[0]);
      endproperty
      a_alm_write: assert property (p_alm_write) else $error("alarm coil not stored"); // see R2

      property p_hi_write;
        @(posedge clk) disable iff (!rstn)
          (reg_wr && reg_kind == KIND_HREG && reg_addr == PW_HREG_BASE + 16'(2*g))
          |=> pw_ff[2*g] == $past(reg_wdata);
      endproperty
      a_hi_write: assert property (p_hi_write) else $error("high width not stored"); // see R3

      // only the start is checked: once running, the low phase legally drops the pin
      property p_alarm_start;
        @(posedge clk) disable iff (!rstn)
          !act[g] ##1
          (alm_ff[g] && wdt_s2_ff && pw_ff[2*g] != PW_OFF && pw_ff[2*g+1] != PW_OFF)
          |=> do_out[g];
      endproperty
      a_alarm_start: assert property (p_alarm_start) else $error("alarm did not start pulses"); // see R2

      property p_pw_write;
        @(posedge clk) disable iff (!rstn)
          (reg_wr && reg_kind == KIND_HREG && reg_addr == PW_HREG_BASE + 16'(2*g + 1))
          |=> pw_ff[2*g+1] == $past(reg_wdata);
      endproperty
      a_pw_write: assert property (p_pw_write) else $error("low width not stored"); // see R3
    end
  endgenerate
endmodule
`default_nettype wire

/* mdp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the register port: one-cycle requests, answer taken at ack
module mdp_host_model (
  // clock
  input wire logic clk,
  // request side
  output logic reg_wr,
  output logic reg_rd,
  output logic reg_kind,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  // answer side
  input wire logic [15:0] reg_rdata_ff,
  input wire logic reg_ack_ff,
  input wire logic reg_err_ff
);
  logic [15:0] rdata;
  logic err;
  logic ok;
  // idle request lines from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_kind = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  // one access; widths written stay in 10..65535 or 0
  task automatic access(input logic wr, input logic kind, input logic [15:0] addr,
                        input logic [15:0] data);
    int n;
    @(negedge clk);
    reg_wr = wr;
    reg_rd = !wr;
    reg_kind = kind;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // scrambled so a design that latches late sees garbage, not the old value
    reg_addr = ~addr;
    reg_wdata = ~data;
    ok = 1'b0;
    for (n = 0; n < 3 && !ok; n++) begin
      if (reg_ack_ff === 1'b1) begin
        ok = 1'b1;
        rdata = reg_rdata_ff;
        err = reg_err_ff;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mdp_pkg::*;
  localparam int MS = 20;
  typedef struct {logic kind; logic [15:0] addr; logic [15:0] data; logic [15:0] exp;
                  logic err;} mdp_row_t;
  logic clk, rstn, wdt_expired, reg_wr, reg_rd, reg_kind, reg_ack_ff, reg_err_ff;
  logic [15:0] reg_addr, reg_wdata, reg_rdata_ff;
  logic [NUM_CH-1:0] do_out;
  int miscompares, tests_run, cyc, i, n;
  // write a row, read it back; includes both ends of each range and one address outside it (one below for the alarm coils)
  mdp_row_t rows [9] = '{
    '{KIND_COIL, 16'h0064, 16'h0001, 16'h0001, 1'b0}, '{KIND_COIL, 16'h006b, 16'h0001, 16'h0001, 1'b0},
    '{KIND_COIL, 16'h006c, 16'h0001, 16'h0000, 1'b1}, '{KIND_COIL, 16'h016c, 16'h0001, 16'h0001, 1'b0},
    '{KIND_COIL, 16'h0173, 16'h0001, 16'h0001, 1'b0}, '{KIND_COIL, 16'h016b, 16'h0001, 16'h0000, 1'b1},
    '{KIND_HREG, 16'h0064, 16'h000a, 16'h000a, 1'b0}, '{KIND_HREG, 16'h0073, 16'hffff, 16'hffff, 1'b0},
    '{KIND_HREG, 16'h0074, 16'h1234, 16'h0000, 1'b1}};
  mdp_pwm #(.MS_CYC(MS)) i_dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_kind(reg_kind), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .reg_ack_ff(reg_ack_ff), .reg_err_ff(reg_err_ff),
    .wdt_expired(wdt_expired), .do_out(do_out));
  mdp_host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_kind(reg_kind),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .reg_ack_ff(reg_ack_ff), .reg_err_ff(reg_err_ff));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, far above the fewer than two thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task do_reset;
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
  endtask
  task wr(input logic kind, input logic [15:0] addr, input logic [15:0] data);
    i_host.access(1'b1, kind, addr, data);
    check(16'(i_host.ok), 16'h0001);
  endtask
  task rd(input logic kind, input logic [15:0] addr, input logic [15:0] exp);
    i_host.access(1'b0, kind, addr, 16'h0000);
    check(16'(i_host.ok), 16'h0001);
    check(i_host.rdata, exp);
  endtask
  // cycles spent at one level, sampled on falling edges, bounded
  task automatic measure(input int ch, input logic lvl, output int cnt);
    cnt = 0;
    while (do_out[ch] === lvl && cnt < 5000) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  initial begin
    wdt_expired = 1'b0;
    rstn = 1'b0;
    do_reset;
    for (i = 0; i < NUM_CH; i++) begin
      rd(KIND_COIL, 16'(EN_COIL_BASE + i), 16'h0000);
      rd(KIND_COIL, 16'(ALM_COIL_BASE + i), 16'h0000);
    end
    for (i = 0; i < PW_WORDS; i++) rd(KIND_HREG, 16'(PW_HREG_BASE + i), PW_RESET);
    check(16'(do_out), 16'h0000);
    $display("test reset values done");
    foreach (rows[k]) begin
      wr(rows[k].kind, rows[k].addr, rows[k].data);
      check(16'(i_host.err), 16'(rows[k].err));
      rd(rows[k].kind, rows[k].addr, rows[k].exp);
      check(16'(i_host.err), 16'(rows[k].err));
    end
    $display("test register table done");
    // ch1: 10 ms high, 12 ms low; the first low phase and the second high phase are measured
    do_reset;
    check(16'(do_out), 16'h0000);
    wr(KIND_HREG, 16'h0066, 16'h000a);
    wr(KIND_HREG, 16'h0067, 16'h000c);
    wr(KIND_COIL, 16'h0065, 16'h0001);
    measure(1, 1'b0, n);
    measure(1, 1'b1, n);
    measure(1, 1'b0, n);
    check(16'(n >= 11 * MS && n <= 13 * MS), 16'h0001);
    measure(1, 1'b1, n);
    check(16'(n >= 9 * MS && n <= 11 * MS), 16'h0001);
    check(16'(do_out & 8'hfd), 16'h0000);
    wr(KIND_COIL, 16'h0065, 16'h0000);
    repeat (2) @(negedge clk);
    check(16'(do_out[1]), 16'h0000);
    $display("test pulse timing done");
    // zero low width keeps the channel quiet although enabled
    wr(KIND_HREG, 16'h0067, PW_OFF);
    wr(KIND_COIL, 16'h0065, 16'h0001);
    n = 0;
    repeat (40 * MS) begin
      @(negedge clk);
      n += int'(do_out[1]);
    end
    check(16'(n), 16'h0000);
    $display("test zero width done");
    // alarm alone waits for the watchdog, then starts within the sync delay
    wr(KIND_COIL, 16'h0065, 16'h0000);
    wr(KIND_HREG, 16'h0067, 16'h000c);
    wr(KIND_COIL, 16'h016d, 16'h0001);
    repeat (3 * MS) @(negedge clk);
    check(16'(do_out[1]), 16'h0000);
    wdt_expired = 1'b1;
    measure(1, 1'b0, n);
    check(16'(n <= 6), 16'h0001);
    wdt_expired = 1'b0;
    repeat (6) @(negedge clk);
    check(16'(do_out[1]), 16'h0000);
    $display("test watchdog alarm done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
